/* verilog/diam_mapper.sv */
/*
 Drive I/O assembly mapper. Unpacks the cyclic output assembly from the
 fieldbus master into drive commands and packs drive status into the
 input assembly, sent on poll or on change of state.
 Assumes the link layer delivers whole assemblies as 16-bit words with a
 one-cycle strobe, and that drive status comes from logic on ref_clk.
*/
//
// Contract
// RL1: Each poll request is answered with the current input assembly. The code ignores poll requests in change-of-state mode.
// RL2: Change-of-state connection sends input assembly only when content changed.
// RL3: Output selector 20 basic, 0/21 extended, 100 vendor, 102 user.
// RL4: Input selector 70 basic, 0/71 extended, 101 vendor, 103 user.
// RL5: Basic, extended, vendor are two words; user assemblies are four.
// RL6: Input and output formats are chosen independently.
// RL7: Basic output: bit0 forward run, bit2 alarm clear, word1 speed reference.
// RL8: Basic input: bit0 latched trip, bit2 running forward, word1 actual speed.
// RL9: Extended output: fwd, rev, run-source bit5, speed-source bit6, speed ref.
// RL10: Source request bits pick fieldbus or local run and speed sources.
// RL11: Extended input byte0 flags: faulted, fwd, rev, ready, sources, at-ref.
// RL12: Extended input byte1 is drive state 1..7; word1 actual speed.
// RL13: Vendor output: fwd, rev, five terminals bits2-6, two terminals byte1.
// RL14: Terminal actions come from their function settings, not the payload.
// RL15: Vendor output byte1 bit7 clears the alarm or fault.
// RL16: Vendor output word1 is per-unit frequency, 20000 equals maximum.
// RL17: Format selector changes apply only after a power cycle (reset).
// RL18: Extended input: reverse bit3, ready bit4, run-source bit5, at-ref bit7.
// RL19: Unused output bits ignored; unused input bits returned as zero.
`timescale 1ns/1ps
module diam_mapper (
	input wire logic ref_clk,
	input wire logic rst_b,
	// Configuration; selectors and cos_mode sampled once after reset release, the others used live
	input wire logic [7:0] output_format_select,
	input wire logic [7:0] input_format_select,
	input wire logic cos_mode,
	input wire logic [15:0] max_frequency_setting,
	input wire logic local_run_fwd,
	input wire logic local_run_rev,
	input wire logic [15:0] local_speed_ref,
	// Output assembly words from the master
	input wire logic out_valid,
	input wire logic [1:0] out_index,
	input wire logic [15:0] out_word,
	input wire logic out_last,
	// Poll request from the master
	input wire logic poll_req,
	// Drive status
	input wire logic drive_tripped,
	input wire logic drive_run_fwd,
	input wire logic drive_run_rev,
	input wire logic drive_ready,
	input wire logic drive_at_ref,
	input wire logic [7:0] drive_state,
	input wire logic [15:0] speed_actual,
	input wire logic [63:0] user_in_data,
	// Drive commands
	output logic forward_run_cmd,
	output logic reverse_run_cmd,
	output logic alarm_reset,
	output logic [15:0] speed_ref,
	output logic [15:0] freq_ref,
	output logic freq_ref_mode,
	output logic run_source_active,
	output logic speed_source_active,
	output logic [4:0] virtual_input_terminals,
	output logic extra_terminal_a,
	output logic extra_terminal_b,
	output logic [63:0] user_out_data,
	output logic user_out_strobe,
	// Input assembly to the master
	output logic in_send,
	output logic [63:0] in_data,
	output logic [2:0] in_words,
	output logic [2:0] out_words,
	output logic cfg_error
);
	//////////////////////////////////////////////////////////////////////////
	// Format selection, latched once after reset

	function automatic logic [2:0] out_decode(input logic [7:0] sel);
		case (sel)
			diam_pkg::OUT_BASIC: out_decode = {1'b1, diam_pkg::DIAM_FMT_BASIC};
			diam_pkg::SEL_DEFAULT,
			diam_pkg::OUT_EXT: out_decode = {1'b1, diam_pkg::DIAM_FMT_EXT};
			diam_pkg::OUT_VENDOR: out_decode = {1'b1, diam_pkg::DIAM_FMT_VENDOR};
			diam_pkg::OUT_USER: out_decode = {1'b1, diam_pkg::DIAM_FMT_USER};
			default: out_decode = {1'b0, diam_pkg::DIAM_FMT_EXT};
		endcase
	endfunction

	function automatic logic [2:0] in_decode(input logic [7:0] sel);
		case (sel)
			diam_pkg::IN_BASIC: in_decode = {1'b1, diam_pkg::DIAM_FMT_BASIC};
			diam_pkg::SEL_DEFAULT,
			diam_pkg::IN_EXT: in_decode = {1'b1, diam_pkg::DIAM_FMT_EXT};
			diam_pkg::IN_VENDOR: in_decode = {1'b1, diam_pkg::DIAM_FMT_VENDOR};
			diam_pkg::IN_USER: in_decode = {1'b1, diam_pkg::DIAM_FMT_USER};
			default: in_decode = {1'b0, diam_pkg::DIAM_FMT_EXT};
		endcase
	endfunction

	function automatic logic [2:0] fmt_len(input diam_pkg::diam_fmt_e f);
		fmt_len = (f == diam_pkg::DIAM_FMT_USER) ? diam_pkg::LEN_LONG : diam_pkg::LEN_SHORT;
	endfunction

	diam_pkg::diam_fmt_e out_fmt_reg;
	diam_pkg::diam_fmt_e in_fmt_reg;
	logic cos_reg;
	logic cfg_done_reg;
	logic [2:0] out_dec;
	logic [2:0] in_dec;

	always_comb begin
		out_dec = out_decode(output_format_select); // [RL3]
		in_dec = in_decode(input_format_select); // [RL4]
	end

	// Selectors are caught at the first edge after reset and held until the
	// next reset, so a live change never reshapes a running connection.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_done_reg <= 1'b0;
			out_fmt_reg <= diam_pkg::DIAM_FMT_EXT;
			in_fmt_reg <= diam_pkg::DIAM_FMT_EXT;
			cos_reg <= 1'b0;
			cfg_error <= 1'b0;
			out_words <= diam_pkg::LEN_SHORT;
			in_words <= diam_pkg::LEN_SHORT;
		end else if (!cfg_done_reg) begin // [RL17]
			cfg_done_reg <= 1'b1;
			// Independent latches: any input format with any output format [RL6]
			out_fmt_reg <= diam_pkg::diam_fmt_e'(out_dec[1:0]);
			in_fmt_reg <= diam_pkg::diam_fmt_e'(in_dec[1:0]);
			cos_reg <= cos_mode;
			cfg_error <= ~(out_dec[2] & in_dec[2]);
			out_words <= fmt_len(diam_pkg::diam_fmt_e'(out_dec[1:0])); // [RL5]
			in_words <= fmt_len(diam_pkg::diam_fmt_e'(in_dec[1:0])); // [RL5]
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Output assembly capture: words collect until the last one is strobed

	logic [15:0] rx_word_reg [4];
	logic [15:0] cmd_word_reg [4];
	logic cmd_new_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_rx
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					rx_word_reg[gi] <= 16'h0000;
				end else if (out_valid && out_index == 2'(gi)) begin
					rx_word_reg[gi] <= out_word;
				end
			end
		end
	endgenerate

	// A frame takes effect as a whole: every command but freq_ref changes in one cycle, freq_ref one cycle later
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_word_reg <= '{default: 16'h0000};
			cmd_new_reg <= 1'b0;
		end else begin
			cmd_new_reg <= 1'b0;
			if (out_valid && out_last && cfg_done_reg) begin
				for (int i = 0; i < 4; i++) begin
					cmd_word_reg[i] <= rx_word_reg[i];
				end
				cmd_word_reg[out_index] <= out_word;
				cmd_new_reg <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Command decode

	logic [15:0] w0;
	logic [15:0] w1;
	logic net_fwd;
	logic net_rev;
	logic run_src_next;
	logic spd_src_next;
	logic reset_next;
	logic [15:0] freq_scaled;

	always_comb begin
		w0 = cmd_word_reg[0];
		w1 = cmd_word_reg[1];
		net_fwd = 1'b0;
		net_rev = 1'b0;
		run_src_next = 1'b1;
		spd_src_next = 1'b1;
		reset_next = 1'b0;
		// Only the documented bits are looked at; the rest are ignored [RL19]
		case (out_fmt_reg)
			diam_pkg::DIAM_FMT_BASIC: begin
				net_fwd = w0[diam_pkg::B_FWD]; // [RL7]
				reset_next = w0[diam_pkg::B_RESET_BASIC]; // [RL7]
			end
			diam_pkg::DIAM_FMT_EXT: begin
				net_fwd = w0[diam_pkg::B_FWD]; // [RL9]
				net_rev = w0[diam_pkg::B_REV]; // [RL9]
				run_src_next = w0[diam_pkg::B_RUN_SRC]; // [RL9]
				spd_src_next = w0[diam_pkg::B_SPD_SRC]; // [RL9]
			end
			diam_pkg::DIAM_FMT_VENDOR: begin
				net_fwd = w0[diam_pkg::B_FWD]; // [RL13]
				net_rev = w0[diam_pkg::B_REV]; // [RL13]
				reset_next = w0[diam_pkg::B_RESET_VENDOR]; // [RL15]
			end
			default: begin
				// User format carries no run command; local sources drive
				run_src_next = 1'b0;
				spd_src_next = 1'b0;
			end
		endcase
	end

	diam_freq_scale u_scale (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pu_value(w1), // [RL16]
		.max_freq(max_frequency_setting),
		.freq_out(freq_scaled)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_source_active <= 1'b0;
			speed_source_active <= 1'b0;
			forward_run_cmd <= 1'b0;
			reverse_run_cmd <= 1'b0;
		end else begin
			run_source_active <= run_src_next;
			speed_source_active <= spd_src_next;
			// Run commands follow the selected source [RL10]
			forward_run_cmd <= run_src_next ? net_fwd : local_run_fwd;
			reverse_run_cmd <= run_src_next ? net_rev : local_run_rev;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			speed_ref <= 16'h0000;
			freq_ref <= 16'h0000;
			freq_ref_mode <= 1'b0;
		end else begin
			freq_ref_mode <= (out_fmt_reg == diam_pkg::DIAM_FMT_VENDOR);
			// Speed reference follows the selected source [RL10]
			speed_ref <= spd_src_next ? w1 : local_speed_ref; // [RL7] [RL9]
			freq_ref <= freq_scaled; // [RL16]
		end
	end

	// Alarm clear is a one-cycle pulse per received frame with the bit set
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_reset <= 1'b0;
		end else begin
			alarm_reset <= cmd_new_reg & reset_next; // [RL7] [RL15]
		end
	end

	// Terminal levels only; their meaning is set by the drive's function
	// settings downstream, never by this block.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			virtual_input_terminals <= 5'h00;
			extra_terminal_a <= 1'b0;
			extra_terminal_b <= 1'b0;
		end else if (out_fmt_reg == diam_pkg::DIAM_FMT_VENDOR) begin
			virtual_input_terminals <= w0[diam_pkg::B_VT_LO +: diam_pkg::N_VT]; // [RL13] [RL14]
			extra_terminal_a <= w0[diam_pkg::B_XA]; // [RL13] [RL14]
			extra_terminal_b <= w0[diam_pkg::B_XB]; // [RL13] [RL14]
		end else begin
			virtual_input_terminals <= 5'h00;
			extra_terminal_a <= 1'b0;
			extra_terminal_b <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			user_out_data <= 64'h0000000000000000;
			user_out_strobe <= 1'b0;
		end else begin
			user_out_strobe <= cmd_new_reg && (out_fmt_reg == diam_pkg::DIAM_FMT_USER);
			user_out_data <= {cmd_word_reg[3], cmd_word_reg[2], cmd_word_reg[1], cmd_word_reg[0]};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Input assembly packing

	logic [63:0] in_pack;
	logic [7:0] flags;

	always_comb begin
		flags = 8'h00;
		in_pack = 64'h0000000000000000; // Unused bits stay zero [RL19]
		case (in_fmt_reg)
			diam_pkg::DIAM_FMT_BASIC: begin
				flags[diam_pkg::B_FAULTED] = drive_tripped; // [RL8]
				flags[diam_pkg::B_RUN_FWD] = drive_run_fwd; // [RL8]
				in_pack[31:0] = {speed_actual, 8'h00, flags}; // [RL8]
			end
			diam_pkg::DIAM_FMT_EXT: begin
				flags[diam_pkg::B_FAULTED] = drive_tripped; // [RL11]
				flags[diam_pkg::B_RUN_FWD] = drive_run_fwd; // [RL11]
				flags[diam_pkg::B_RUN_REV] = drive_run_rev; // [RL18]
				flags[diam_pkg::B_READY] = drive_ready; // [RL18]
				flags[diam_pkg::B_RUN_ACT] = run_source_active; // [RL18]
				flags[diam_pkg::B_SPD_ACT] = speed_source_active; // [RL11]
				flags[diam_pkg::B_AT_REF] = drive_at_ref; // [RL18]
				in_pack[31:0] = {speed_actual, 16'h0000} | {16'h0000, 8'h00, flags};
				// Out-of-range state codes are reported as zero [RL12]
				if (drive_state >= diam_pkg::ST_STARTUP && drive_state <= diam_pkg::ST_FAULTED) begin
					in_pack[diam_pkg::B_STATE_LO +: 8] = drive_state; // [RL12]
				end
			end
			diam_pkg::DIAM_FMT_VENDOR: begin
				// Layout of this assembly is supplied by the drive core
				in_pack[31:0] = user_in_data[31:0];
			end
			default: begin
				in_pack = user_in_data;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Transmission: poll mode answers every poll; change-of-state mode sends once after reset, then only on a difference

	logic [63:0] last_sent_reg;
	logic sent_once_reg;
	logic send_now;

	always_comb begin
		if (cos_reg) begin
			send_now = cfg_done_reg && (!sent_once_reg || in_pack != last_sent_reg); // [RL2]
		end else begin
			send_now = cfg_done_reg && poll_req; // [RL1]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_send <= 1'b0;
			in_data <= 64'h0000000000000000;
			last_sent_reg <= 64'h0000000000000000;
			sent_once_reg <= 1'b0;
		end else begin
			in_send <= send_now;
			if (send_now) begin
				in_data <= in_pack; // [RL1] [RL2]
				last_sent_reg <= in_pack;
				sent_once_reg <= 1'b1;
			end
		end
	end
endmodule // diam_mapper

/* verilog/diam_pkg.sv */
/*
 Shared constants for the drive I/O assembly mapper: format selector codes,
 bit positions inside the cyclic payload words, drive state codes, scaling.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package diam_pkg;
	// Format selector codes, as written in the configuration setting
	localparam logic [7:0] SEL_DEFAULT = 8'h00;
	localparam logic [7:0] OUT_BASIC = 8'h14;
	localparam logic [7:0] OUT_EXT = 8'h15;
	localparam logic [7:0] OUT_VENDOR = 8'h64;
	localparam logic [7:0] OUT_USER = 8'h66;
	localparam logic [7:0] IN_BASIC = 8'h46;
	localparam logic [7:0] IN_EXT = 8'h47;
	localparam logic [7:0] IN_VENDOR = 8'h65;
	localparam logic [7:0] IN_USER = 8'h67;

	typedef enum logic [1:0] {
		DIAM_FMT_BASIC = 2'b00,
		DIAM_FMT_EXT = 2'b01,
		DIAM_FMT_VENDOR = 2'b10,
		DIAM_FMT_USER = 2'b11
	} diam_fmt_e;

	// Assembly lengths in 16-bit words
	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_LONG = 3'h4;

	// Output byte 0 / byte 1 bit positions (byte 1 bits are offset by 8 in word 0)
	localparam int B_FWD = 0;
	localparam int B_REV = 1;
	localparam int B_RESET_BASIC = 2;
	localparam int B_RUN_SRC = 5;
	localparam int B_SPD_SRC = 6;
	localparam int B_VT_LO = 2;
	localparam int N_VT = 5;
	localparam int B_XA = 13;
	localparam int B_XB = 14;
	localparam int B_RESET_VENDOR = 15;

	// Input byte 0 bit positions, and the first bit of byte 1
	localparam int B_FAULTED = 0;
	localparam int B_RUN_FWD = 2;
	localparam int B_RUN_REV = 3;
	localparam int B_READY = 4;
	localparam int B_RUN_ACT = 5;
	localparam int B_SPD_ACT = 6;
	localparam int B_AT_REF = 7;
	localparam int B_STATE_LO = 8;

	// Drive state codes reported in extended input byte 1
	localparam logic [7:0] ST_STARTUP = 8'h01;
	localparam logic [7:0] ST_FAULTED = 8'h07;

	// Per-unit frequency: this value equals the configured maximum frequency
	localparam logic [15:0] PU_FULL = 16'h4E20;
endpackage

/* verilog/diam_freq_scale.sv */
/*
 Converts a per-unit frequency command into a frequency in the units of the
 maximum frequency setting: value * max / full scale. Registered output,
 one cycle latency. Assumes inputs on the same clock.
*/
`timescale 1ns/1ps
module diam_freq_scale (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [15:0] pu_value,
	input wire logic [15:0] max_freq,
	output logic [15:0] freq_out
);
	logic [31:0] product;
	logic [31:0] quotient;

	always_comb begin
		product = 32'(pu_value) * 32'(max_freq);
		quotient = product / 32'(diam_pkg::PU_FULL);
	end

	// Clip at the maximum: a command above full scale, or a speed word seen
	// outside the frequency format, never asks for more than the maximum
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			freq_out <= 16'h0000;
		end else if (quotient > 32'(max_freq)) begin
			freq_out <= max_freq;
		end else begin
			freq_out <= quotient[15:0];
		end
	end
endmodule // diam_freq_scale

/* test/diam_master_model.sv */
/*
 Fieldbus master model: sends whole output assemblies word by word and
 issues poll pulses. Assumes the mapper samples on the rising ref_clk edge.
*/
`timescale 1ns/1ps
module diam_master_model (
	input wire logic ref_clk,
	output logic out_valid,
	output logic [1:0] out_index,
	output logic [15:0] out_word,
	output logic out_last,
	output logic poll_req
);
	initial begin
		out_valid = 1'b0;
		out_index = 2'h0;
		out_word = 16'h0000;
		out_last = 1'b0;
		poll_req = 1'b0;
	end
	// Always the full assembly length; a short frame would be a master fault
	task automatic send(input logic [63:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			#1;
			out_valid = 1'b1;
			out_index = 2'(i);
			out_word = d[16*i +: 16];
			out_last = (i == n - 1);
		end
		@(posedge ref_clk);
		#1;
		out_valid = 1'b0;
		out_last = 1'b0;
		// Released lines toggle so a stale word is never mistaken for data
		out_word = ~out_word;
		out_index = ~out_index;
	endtask
	task automatic poll();
		@(posedge ref_clk);
		#1;
		poll_req = 1'b1;
		@(posedge ref_clk);
		#1;
		poll_req = 1'b0;
	endtask
endmodule // diam_master_model

/* test/diam_mapper_props.sv */
/*
 Port checker for diam_mapper, bound to every instance.
 Assumes cos_mode and max_frequency_setting stay steady out of reset.
*/
`timescale 1ns/1ps
module diam_mapper_props (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cos_mode,
	input wire logic [15:0] max_frequency_setting,
	input wire logic out_valid,
	input wire logic out_last,
	input wire logic poll_req,
	input wire logic forward_run_cmd,
	input wire logic reverse_run_cmd,
	input wire logic alarm_reset,
	input wire logic [15:0] freq_ref,
	input wire logic freq_ref_mode,
	input wire logic [4:0] virtual_input_terminals,
	input wire logic extra_terminal_a,
	input wire logic extra_terminal_b,
	input wire logic in_send,
	input wire logic [2:0] in_words,
	input wire logic [2:0] out_words
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	a_poll_answer: assert property (!cos_mode && poll_req |-> ##1 in_send)
		else $error("poll request not answered");
	a_send_on_poll: assert property (!cos_mode && in_send |-> $past(poll_req))
		else $error("unrequested send in poll mode");
	a_len_codes: assert property (out_words inside {3'h2, 3'h4} && in_words inside {3'h2, 3'h4})
		else $error("assembly length not 2 or 4 words");
	// Format is frozen once latched; only a reset may change it
	a_fmt_frozen: assert property ($past(rst_b, 3) |-> $stable(in_words) && $stable(out_words))
		else $error("assembly length changed without reset");
	a_vendor_terms: assert property (!freq_ref_mode |->
		{virtual_input_terminals, extra_terminal_a, extra_terminal_b} == 7'h00)
		else $error("terminals driven outside vendor format");
	a_cmd_hold: assert property ((freq_ref_mode && !(out_valid && out_last)) [*3] |=>
		$stable({forward_run_cmd, reverse_run_cmd}))
		else $error("run command moved without a frame");
	a_reset_pulse: assert property (alarm_reset |=> !alarm_reset)
		else $error("alarm reset longer than one cycle");
	a_freq_limit: assert property (freq_ref <= max_frequency_setting)
		else $error("frequency above maximum");
	c_poll: cover property (!cos_mode && poll_req ##1 in_send);
	c_cos_send: cover property (cos_mode && in_send);
	c_vendor_reset: cover property (alarm_reset && freq_ref_mode);
endmodule // diam_mapper_props
bind diam_mapper diam_mapper_props i_diam_mapper_props (.ref_clk, .rst_b, .cos_mode,
	.max_frequency_setting, .out_valid, .out_last, .poll_req, .forward_run_cmd,
	.reverse_run_cmd, .alarm_reset, .freq_ref, .freq_ref_mode, .virtual_input_terminals,
	.extra_terminal_a, .extra_terminal_b, .in_send, .in_words, .out_words);

/* test/diam_mapper_tb.sv */
/*
 Testbench for diam_mapper: resets per format pair, sends assemblies and
 polls through the master model, checks ports. Assumes model and checker.
*/
`timescale 1ns/1ps
module diam_mapper_tb;
	logic ref_clk, rst_b, cos_mode, out_valid, out_last, poll_req, in_send, cfg_error;
	logic local_run_fwd, local_run_rev, drive_tripped, drive_run_fwd, drive_run_rev;
	logic drive_ready, drive_at_ref, forward_run_cmd, reverse_run_cmd, alarm_reset;
	logic freq_ref_mode, run_source_active, speed_source_active, user_out_strobe;
	logic extra_terminal_a, extra_terminal_b;
	logic [1:0] out_index;
	logic [2:0] in_words, out_words;
	logic [4:0] virtual_input_terminals;
	logic [7:0] output_format_select, input_format_select, drive_state;
	logic [15:0] max_frequency_setting, local_speed_ref, out_word, speed_actual;
	logic [15:0] speed_ref, freq_ref;
	logic [63:0] user_in_data, user_out_data, in_data;
	logic [7:0] tab_o [6] = '{8'h00, 8'h15, 8'h14, 8'h64, 8'h66, 8'h33};
	logic [7:0] tab_i [6] = '{8'h67, 8'h47, 8'h65, 8'h46, 8'h00, 8'h47};
	logic [5:0] tab_w [6] = '{6'h14, 6'h12, 6'h12, 6'h12, 6'h22, 6'h12};
	int n_mismatch = 0;
	int n_compared = 0;
	diam_mapper i_diam_mapper (.ref_clk, .rst_b, .output_format_select, .input_format_select,
		.cos_mode, .max_frequency_setting, .local_run_fwd, .local_run_rev, .local_speed_ref,
		.out_valid, .out_index, .out_word, .out_last, .poll_req, .drive_tripped,
		.drive_run_fwd, .drive_run_rev, .drive_ready, .drive_at_ref, .drive_state,
		.speed_actual, .user_in_data, .forward_run_cmd, .reverse_run_cmd, .alarm_reset,
		.speed_ref, .freq_ref, .freq_ref_mode, .run_source_active, .speed_source_active,
		.virtual_input_terminals, .extra_terminal_a, .extra_terminal_b, .user_out_data,
		.user_out_strobe, .in_send, .in_data, .in_words, .out_words, .cfg_error);
	diam_master_model i_diam_master_model (.ref_clk, .out_valid, .out_index, .out_word,
		.out_last, .poll_req);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Selectors only take hold across a reset, as after a power cycle
	task automatic restart(input logic [7:0] o, input logic [7:0] i, input logic c);
		output_format_select = o;
		input_format_select = i;
		cos_mode = c;
		rst_b = 1'b0;
		repeat (10) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic frame(input logic [63:0] d, input int n);
		i_diam_master_model.send(d, n);
		// Commands but freq_ref, and the alarm clear pulse, stand one edge after the frame; freq_ref one edge later
		@(posedge ref_clk);
		#1;
	endtask
	// The model returns just after the edge that answers the poll
	task automatic poll_chk(input logic [63:0] exp);
		i_diam_master_model.poll();
		chk("in_send", in_send, 1'b1);
		chk("in_data", in_data, exp);
	endtask
	task automatic count_sends(input int n, input int exp);
		int s;
		s = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			s += in_send;
		end
		chk("send_count", s, exp);
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{local_run_fwd, local_run_rev, drive_tripped, drive_run_fwd, drive_run_rev} = '0;
		{drive_ready, drive_at_ref} = '0;
		drive_state = 8'h00;
		speed_actual = 16'hABCD;
		max_frequency_setting = 16'h0258;
		local_speed_ref = 16'h0777;
		user_in_data = 64'h1122_3344_5566_7788;
		for (int k = 0; k < 6; k++) begin
			restart(tab_o[k], tab_i[k], 1'b0);
			tick();
			chk("out_words", out_words, tab_w[k][5:3]);
			chk("in_words", in_words, tab_w[k][2:0]);
			chk("cfg_error", cfg_error, k == 5);
			chk("freq_mode", freq_ref_mode, tab_o[k] == 8'h64);
		end
		restart(8'h15, 8'h47, 1'b0);
		frame(64'h1234_0061, 2);
		chk("fwd", forward_run_cmd, 1'b1);
		chk("speed_ref", speed_ref, 16'h1234);
		chk("sources", {run_source_active, speed_source_active}, 2'h3);
		{drive_tripped, drive_run_rev, drive_ready, drive_at_ref} = 4'hF;
		drive_state = 8'h05;
		poll_chk(64'h0000_0000_ABCD_05F9);
		local_run_rev = 1'b1;
		frame(64'h5555_FF01, 2);
		chk("run_cmds", {forward_run_cmd, reverse_run_cmd}, 2'h1);
		chk("speed_ref", speed_ref, 16'h0777);
		drive_state = 8'h09;
		drive_tripped = 1'b0;
		poll_chk(64'h0000_0000_ABCD_0098);
		local_run_rev = 1'b0;
		drive_tripped = 1'b1;
		drive_run_fwd = 1'b1;
		restart(8'h14, 8'h46, 1'b0);
		frame(64'h0BB8_FF65, 2);
		chk("basic_cmds", {forward_run_cmd, reverse_run_cmd, alarm_reset}, 3'h5);
		chk("speed_ref", speed_ref, 16'h0BB8);
		tick();
		chk("alarm_reset", alarm_reset, 1'b0);
		poll_chk(64'h0000_0000_ABCD_0005);
		restart(8'h64, 8'h65, 1'b0);
		frame(64'h2710_E17F, 2);
		chk("vendor_cmds", {forward_run_cmd, reverse_run_cmd, alarm_reset}, 3'h7);
		chk("terminals", {virtual_input_terminals, extra_terminal_a, extra_terminal_b}, 7'h7F);
		tick();
		chk("freq_ref", freq_ref, 16'h012C);
		frame(64'h4E20_0000, 2);
		tick();
		chk("freq_ref", freq_ref, 16'h0258);
		chk("terminals", {virtual_input_terminals, extra_terminal_a, extra_terminal_b}, 7'h00);
		poll_chk(64'h0000_0000_5566_7788);
		restart(8'h66, 8'h67, 1'b0);
		frame(64'hCAFE_F00D_1357_9BDF, 4);
		chk("user_out", user_out_data, 64'hCAFE_F00D_1357_9BDF);
		chk("user_strobe", user_out_strobe, 1'b1);
		poll_chk(64'h1122_3344_5566_7788);
		output_format_select = 8'h14;
		repeat (3) tick();
		chk("out_words", out_words, 3'h4);
		restart(8'h15, 8'h47, 1'b1);
		count_sends(8, 1);
		i_diam_master_model.poll();
		count_sends(4, 0);
		drive_ready = ~drive_ready;
		count_sends(6, 1);
		conclude();
	end
endmodule // diam_mapper_tb
